/* File: core/spf_pkg.sv */
// Shared types and constants for the self-programming flash sequencer
// Notes on behaviour
// [R01] Unsupported combinations retire as plain no-ops
// [R02] RAM code reading/writing RAM blocks
// [R03] RAM code on flash: non-blocking, write no-op
// [R04] Flash code on RAM blocks; flash program no-op
// [R05] Flash code on flash: read blocks, rest no-op
// [R06] Write permit clear makes program/erase no-op
// [R07] Blocking instruction takes four core cycles
// [R08] Non-blocking launches operation; busy until done
// [R09] Sixteen-bit data buffer loads and unloads memory
// [R10] Twenty-four-bit pointer addresses all accesses
// [R11] Low-byte add carry increments upper bytes
// [R12] Low-byte subtract borrow decrements upper bytes
// [R13] Code-protect fuse never blocks these accesses
// [R14] Erase clears whole 512-byte block
// [R15] Configuration block unreachable by these instructions
// [R16] Software never fetches flash while busy
// [R17] Software waits three cycles before polling
// [R18] Flash execution wait codes give 1-4 clocks
// [R19] Slower of speed and wait; RAM restores
// [R20] Flash read wait codes give 1-4 clocks
// [R21] Time base divides core clock by table
// [R22] Software keeps time base 1-2 microseconds
// [R23] Software keeps core speed during flash operations
// [R24] Single-clock read cannot be broken by interrupts
// [R25] Timing field positions chosen locally
`default_nettype none

package spf_pkg;

    // ----------------------------------------------------------------
    // Address map
    // ----------------------------------------------------------------
    localparam logic [23:0] FLASH_BASE = 24'h01_0000;
    localparam logic [23:0] CONFIG_BASE = 24'hFF_0000;
    localparam int ERASE_LSB = 9;
    localparam logic [23:0] PTR_STEP = 24'h00_0001;

    // ----------------------------------------------------------------
    // Timing register layout and reset
    // ----------------------------------------------------------------
    localparam int EXEC_WAIT_LSB = 6;
    localparam int READ_WAIT_LSB = 4;
    localparam int WR_DIV_LSB = 0;
    localparam logic [7:0] TIMING_RESET = 8'h00;
    localparam logic [15:0] DBUF_RESET = 16'h0000;
    localparam logic [23:0] PTR_RESET = 24'h00_0000;

    // ----------------------------------------------------------------
    // Cycle counts
    // ----------------------------------------------------------------
    localparam logic [1:0] BLK_STALL = 2'h3;
    localparam logic [1:0] RAM_RD_LAT = 2'h1;

    // Instruction and register selectors from the core
    typedef enum logic [2:0] {
        OP_READ, OP_READ_INC, OP_WRITE, OP_WRITE_INC, OP_FL_WRITE, OP_FL_ERASE
    } op_t;

    typedef enum logic [2:0] {
        SEL_TIMING, SEL_DATA_HI, SEL_DATA_LO, SEL_ADDR_UP, SEL_ADDR_MID, SEL_ADDR_LO
    } reg_sel_t;

    typedef enum {ACC_IDLE, ACC_RAM_RD, ACC_FL_RD, ACC_PROG} acc_t;

    // Erase/write time base divisor per select code
    function automatic logic [8:0] wr_divisor(input logic [3:0] sel);
        case (sel)
            4'h0: return 9'h002;
            4'h1: return 9'h003;
            4'h2: return 9'h004;
            4'h3: return 9'h006;
            4'h4: return 9'h008;
            4'h5: return 9'h00C;
            4'h6: return 9'h010;
            4'h7: return 9'h018;
            4'h8: return 9'h020;
            4'h9: return 9'h030;
            4'hA: return 9'h040;
            4'hB: return 9'h060;
            4'hC: return 9'h080;
            4'hD: return 9'h0C0;
            4'hE: return 9'h100;
            default: return 9'h180;
        endcase
    endfunction

endpackage

`default_nettype wire

/* File: core/pulse_divider.sv */
// Enable divider that emits one pulse every div_in input enables
`default_nettype none

module pulse_divider #(
    parameter int W = 9
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic en_in,
    input wire logic [W-1:0] div_in,
    output logic tick_out
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } div_st_t;

    div_st_t s;
    div_st_t next_s;
    logic last;

    // Greater-or-equal so a shrinking divisor never strands the count
    always_comb begin
        last = (div_in <= W'(1)) || (s.cnt >= (div_in - W'(1)));
        tick_out = en_in && last;
        next_s = s;
        if (en_in) begin
            next_s.cnt = last ? '0 : s.cnt + W'(1);
        end
    end

    // Count register
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

`default_nettype wire

/* File: core/self_programming_flash_ctrl.sv */
// Self-programming sequencer: decode, pointer, buffer, flash timing
`default_nettype none

module self_programming_flash_ctrl (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic instr_valid_in,
    input wire spf_pkg::op_t instr_op_in,
    input wire logic exec_from_flash_in,
    input wire logic flash_write_permit_in,
    input wire logic [7:0] core_speed_div_in,
    output logic core_ce_out,
    output logic stall_out,
    output logic nop_out,
    output logic flash_op_pending_flag_out,
    input wire logic reg_wr_in,
    input wire spf_pkg::reg_sel_t reg_sel_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic ptr_add_in,
    input wire logic ptr_sub_in,
    input wire logic [7:0] ptr_operand_in,
    output logic [7:0] flash_timing_config_out,
    output logic [15:0] prog_mem_data_buffer_out,
    output logic [23:0] prog_mem_address_pointer_out,
    output logic [23:0] mem_addr_out,
    output logic [15:0] mem_wdata_out,
    output logic pram_rd_out,
    output logic pram_wr_out,
    input wire logic [15:0] pram_rdata_in,
    output logic flash_rd_out,
    output logic flash_write_out,
    output logic flash_erase_out,
    output logic flash_tick_out,
    input wire logic [15:0] flash_rdata_in,
    input wire logic flash_done_in
);
    import spf_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] timing;
        logic [15:0] dbuf;
        logic [23:0] ptr;
        logic [23:0] addr;
        logic busy;
        logic [1:0] blk;
        acc_t acc;
        logic [1:0] cnt;
        logic inc;
        logic pram_rd;
        logic pram_wr;
        logic fl_rd;
        logic fl_wr;
        logic fl_er;
    } ctrl_st_t;

    ctrl_st_t s;
    ctrl_st_t next_s;

    logic to_flash;
    logic in_cfg;
    logic idle;
    logic is_rd;
    logic is_wr;
    logic is_prog;
    logic is_inc;
    logic go;
    logic ram_rd;
    logic ram_wr;
    logic fl_rd_blk;
    logic fl_rd_nb;
    logic fl_prog;
    logic blocking;
    logic launched;
    logic [1:0] exec_wait;
    logic [1:0] read_wait;
    logic [3:0] wr_sel;
    logic [7:0] wait_div;
    logic [7:0] eff_div;
    logic [8:0] lo_sum;
    logic [8:0] lo_diff;

    // ----------------------------------------------------------------
    // Timing fields and clock enables
    // ----------------------------------------------------------------
    assign exec_wait = s.timing[EXEC_WAIT_LSB +: 2]; // R25
    assign read_wait = s.timing[READ_WAIT_LSB +: 2]; // R25
    assign wr_sel = s.timing[WR_DIV_LSB +: 4]; // R25
    assign wait_div = {6'h00, exec_wait} + 8'h01;

    // Flash fetch stretches the core cycle, RAM fetch uses speed alone
    always_comb begin
        eff_div = core_speed_div_in;
        if (exec_from_flash_in && (wait_div > core_speed_div_in)) begin
            eff_div = wait_div; // R18 R19
        end
    end

    // Core cycle enable from the system clock
    pulse_divider #(.W(9)) u_core_div (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .en_in(1'b1),
        .div_in({1'b0, eff_div}),
        .tick_out(core_ce_out)
    );

    // Erase/write time base counted in core cycles
    pulse_divider #(.W(9)) u_wr_div (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .en_in(core_ce_out),
        .div_in(wr_divisor(wr_sel)), // R21
        .tick_out(flash_tick_out)
    );

    // ----------------------------------------------------------------
    // Instruction decode
    // ----------------------------------------------------------------
    // No fuse input at all: code protection cannot gate anything here
    always_comb begin
        to_flash = s.ptr >= FLASH_BASE; // R13
        in_cfg = s.ptr >= CONFIG_BASE; // R15
        idle = s.acc == ACC_IDLE;
        is_rd = (instr_op_in == OP_READ) || (instr_op_in == OP_READ_INC);
        is_wr = (instr_op_in == OP_WRITE) || (instr_op_in == OP_WRITE_INC);
        is_prog = (instr_op_in == OP_FL_WRITE) || (instr_op_in == OP_FL_ERASE);
        is_inc = (instr_op_in == OP_READ_INC) || (instr_op_in == OP_WRITE_INC);
        go = instr_valid_in && idle;
        ram_rd = go && is_rd && !to_flash; // R02 R04
        ram_wr = go && is_wr && !to_flash; // R02 R04
        fl_rd_blk = go && is_rd && to_flash && !in_cfg && exec_from_flash_in; // R05
        fl_rd_nb = go && is_rd && to_flash && !in_cfg && !exec_from_flash_in; // R03
        fl_prog = go && is_prog && to_flash && !in_cfg && !exec_from_flash_in
            && flash_write_permit_in; // R03 R06
        blocking = ram_rd || ram_wr || fl_rd_blk;
        launched = blocking || fl_rd_nb || fl_prog;
    end

    // Anything not launched retires with no side effect
    assign nop_out = instr_valid_in && !launched; // R01
    assign stall_out = s.blk != 2'h0; // R07

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.pram_rd = 1'b0;
        next_s.pram_wr = 1'b0;
        next_s.fl_wr = 1'b0;
        next_s.fl_er = 1'b0;
        lo_sum = '0;
        lo_diff = '0;

        // Software writes to the special registers
        if (reg_wr_in) begin
            case (reg_sel_in)
                SEL_TIMING: next_s.timing = reg_wdata_in;
                SEL_DATA_HI: next_s.dbuf[15:8] = reg_wdata_in;
                SEL_DATA_LO: next_s.dbuf[7:0] = reg_wdata_in;
                SEL_ADDR_UP: next_s.ptr[23:16] = reg_wdata_in;
                SEL_ADDR_MID: next_s.ptr[15:8] = reg_wdata_in;
                SEL_ADDR_LO: next_s.ptr[7:0] = reg_wdata_in;
                default: next_s.timing = s.timing;
            endcase
        end

        // Low-byte arithmetic ripples into the upper two bytes
        if (ptr_add_in) begin
            lo_sum = {1'b0, next_s.ptr[7:0]} + {1'b0, ptr_operand_in};
            next_s.ptr[7:0] = lo_sum[7:0];
            next_s.ptr[23:8] = next_s.ptr[23:8] + {15'h0000, lo_sum[8]}; // R11
        end else if (ptr_sub_in) begin
            lo_diff = {1'b0, next_s.ptr[7:0]} - {1'b0, ptr_operand_in};
            next_s.ptr[7:0] = lo_diff[7:0];
            next_s.ptr[23:8] = next_s.ptr[23:8] - {15'h0000, lo_diff[8]}; // R12
        end

        // Stall window of a blocking instruction
        if (blocking) begin
            next_s.blk = BLK_STALL; // R07
        end else if (stall_out && core_ce_out) begin
            next_s.blk = s.blk - 2'h1;
        end

        // Memory access engine; hardware updates win over software
        case (s.acc)
            ACC_IDLE: begin
                if (ram_rd) begin
                    next_s.acc = ACC_RAM_RD;
                    next_s.pram_rd = 1'b1;
                    next_s.cnt = RAM_RD_LAT;
                    next_s.addr = s.ptr; // R10
                    next_s.inc = is_inc;
                end else if (ram_wr) begin
                    next_s.pram_wr = 1'b1; // R09
                    next_s.addr = s.ptr;
                    if (is_inc) begin
                        next_s.ptr = s.ptr + PTR_STEP;
                    end
                end else if (fl_rd_blk || fl_rd_nb) begin
                    next_s.acc = ACC_FL_RD;
                    next_s.fl_rd = 1'b1;
                    next_s.cnt = read_wait; // R20
                    next_s.addr = s.ptr;
                    next_s.inc = is_inc;
                    next_s.busy = fl_rd_nb; // R08
                end else if (fl_prog) begin
                    next_s.acc = ACC_PROG;
                    next_s.busy = 1'b1; // R08
                    if (instr_op_in == OP_FL_ERASE) begin
                        next_s.fl_er = 1'b1;
                        next_s.addr = {s.ptr[23:ERASE_LSB], {ERASE_LSB{1'b0}}}; // R14
                    end else begin
                        next_s.fl_wr = 1'b1;
                        next_s.addr = s.ptr;
                    end
                end
            end
            ACC_RAM_RD: begin
                if (s.cnt == 2'h0) begin
                    next_s.dbuf = pram_rdata_in; // R09
                    next_s.acc = ACC_IDLE;
                    if (s.inc) begin
                        next_s.ptr = s.ptr + PTR_STEP;
                    end
                end else begin
                    next_s.cnt = s.cnt - 2'h1;
                end
            end
            ACC_FL_RD: begin
                // Self-timed in system clocks, so core-speed changes cannot cut it short
                if (s.cnt == 2'h0) begin
                    next_s.dbuf = flash_rdata_in; // R24
                    next_s.fl_rd = 1'b0;
                    next_s.busy = 1'b0;
                    next_s.acc = ACC_IDLE;
                    if (s.inc) begin
                        next_s.ptr = s.ptr + PTR_STEP;
                    end
                end else begin
                    next_s.cnt = s.cnt - 2'h1;
                end
            end
            ACC_PROG: begin
                if (flash_done_in) begin
                    next_s.busy = 1'b0; // R08
                    next_s.acc = ACC_IDLE;
                end
            end
            default: next_s.acc = ACC_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0;
            s.timing <= TIMING_RESET;
            s.dbuf <= DBUF_RESET;
            s.ptr <= PTR_RESET;
            s.acc <= ACC_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign flash_op_pending_flag_out = s.busy;
    assign flash_timing_config_out = s.timing;
    assign prog_mem_data_buffer_out = s.dbuf;
    assign prog_mem_address_pointer_out = s.ptr;
    assign mem_addr_out = s.addr;
    assign mem_wdata_out = s.dbuf;
    assign pram_rd_out = s.pram_rd;
    assign pram_wr_out = s.pram_wr;
    assign flash_rd_out = s.fl_rd;
    assign flash_write_out = s.fl_wr;
    assign flash_erase_out = s.fl_er;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // Core cycles seen inside a stall window
    logic [2:0] ce_seen;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ce_seen <= 3'h0;
        end else if (!stall_out) begin
            ce_seen <= 3'h0;
        end else if (core_ce_out) begin
            ce_seen <= ce_seen + 3'h1;
        end
    end

    stall_length_a: assert property ( // R07
        $fell(stall_out) |-> ce_seen == {1'b0, BLK_STALL})
        else $error("blocking stall not three further core cycles");

    permit_nop_a: assert property ( // R06
        (instr_valid_in && is_prog && !flash_write_permit_in)
            |-> nop_out ##1 (!flash_write_out && !flash_erase_out))
        else $error("program or erase ran without write permit");

    flash_exec_nop_a: assert property ( // R05
        (instr_valid_in && exec_from_flash_in && to_flash && (is_wr || is_prog))
            |-> nop_out ##1 (!pram_wr_out && !flash_write_out && !flash_erase_out))
        else $error("flash-resident code altered flash");

    nb_launch_a: assert property ( // R08
        (fl_prog || fl_rd_nb) |=> (flash_op_pending_flag_out && !stall_out))
        else $error("non-blocking launch did not raise busy");

    busy_release_a: assert property ( // R08
        (s.acc == ACC_PROG && flash_done_in) |=> !flash_op_pending_flag_out)
        else $error("busy stayed set after flash completion");

    ptr_carry_a: assert property ( // R11
        (ptr_add_in && !reg_wr_in && idle && !instr_valid_in
            && ({1'b0, s.ptr[7:0]} + {1'b0, ptr_operand_in} > 9'h0FF))
            |=> s.ptr[23:8] == $past(s.ptr[23:8]) + 16'h0001)
        else $error("pointer carry lost");

    ptr_borrow_a: assert property ( // R12
        (ptr_sub_in && !ptr_add_in && !reg_wr_in && idle && !instr_valid_in
            && (ptr_operand_in > s.ptr[7:0]))
            |=> s.ptr[23:8] == $past(s.ptr[23:8]) - 16'h0001)
        else $error("pointer borrow lost");

    erase_align_a: assert property ( // R14
        flash_erase_out |-> mem_addr_out[ERASE_LSB-1:0] == '0)
        else $error("erase address not block aligned");

    cfg_guard_a: assert property ( // R15
        (flash_write_out || flash_erase_out || $rose(flash_rd_out))
            |-> mem_addr_out < CONFIG_BASE)
        else $error("configuration block reached");

    read_fast_a: assert property ( // R20
        ($rose(flash_rd_out) && read_wait == 2'h0) |=> !flash_rd_out)
        else $error("single-clock flash read overran");

    read_slow_a: assert property ( // R20
        ($rose(flash_rd_out) && read_wait == 2'h3)
            |-> flash_rd_out [*4] ##1 !flash_rd_out)
        else $error("four-clock flash read wrong length");

    exec_wait_a: assert property ( // R18
        (core_ce_out && exec_from_flash_in && exec_wait == 2'h3
            && core_speed_div_in <= 8'h01)
            |=> (!core_ce_out || !exec_from_flash_in) [*3])
        else $error("flash execution wait too short");

endmodule

`default_nettype wire

/* File: bench/mem_model.sv */
// Behavioural program RAM and flash array facing the sequencer
`default_nettype none
module mem_model #(
    parameter int DONE_LAT = 900
) (
    input wire logic sys_clk_in,
    input wire logic [23:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic pram_rd_in,
    input wire logic pram_wr_in,
    input wire logic flash_rd_in,
    input wire logic flash_prog_in,
    output logic [15:0] pram_rdata_out,
    output logic [15:0] flash_rdata_out,
    output logic flash_done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ram [16];
    logic [15:0] churn = 16'h0000;
    logic [3:0] rd_addr = 4'h0;
    logic rd_q = 1'b0;
    int left = 0;
    initial flash_done_out = 1'b0;
    initial for (int i = 0; i < 16; i++) ram[i] = 16'h1111 * 16'(i);
    // Stale data churns so a late sample never matches by luck
    always @(posedge sys_clk_in) begin
        churn <= churn + 16'h3C5B;
        rd_q <= pram_rd_in;
        rd_addr <= addr_in[3:0];
        if (pram_wr_in) begin
            ram[addr_in[3:0]] <= wdata_in;
        end
        // Array stays busy for a fixed count, then pulses done
        flash_done_out <= (left == 1);
        if (flash_prog_in) begin
            left <= DONE_LAT;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
    assign pram_rdata_out = rd_q ? ram[rd_addr] : churn;
    assign flash_rdata_out = flash_rd_in ? {addr_in[7:0], ~addr_in[7:0]} : churn;
endmodule
`default_nettype wire

/* File: bench/test_self_programming_flash_ctrl.sv */
// Self-checking bench for the self-programming flash sequencer
`default_nettype none
module test_self_programming_flash_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import spf_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, iv = 1'b0, eff = 1'b0, wp = 1'b1;
    logic rw = 1'b0, padd = 1'b0, psub = 1'b0;
    logic [7:0] spd = 8'h01, rd = 8'h00, pop = 8'h00;
    op_t op = OP_READ;
    reg_sel_t rs = SEL_TIMING;
    logic ce, stall, nop, busy, prd, pwr, frd, fwr, fer, tick, done;
    logic [7:0] tcfg;
    logic [15:0] dbuf, mwd, prdata, frdata;
    logic [23:0] ptr, maddr;
    int bad_count = 0, tests_run = 0;
    always #2.5 clk = ~clk;
    self_programming_flash_ctrl dut (
        .sys_clk_in(clk), .rst_b_in(rst_b), .instr_valid_in(iv), .instr_op_in(op),
        .exec_from_flash_in(eff), .flash_write_permit_in(wp), .core_speed_div_in(spd),
        .core_ce_out(ce), .stall_out(stall), .nop_out(nop), .flash_op_pending_flag_out(busy),
        .reg_wr_in(rw), .reg_sel_in(rs), .reg_wdata_in(rd), .ptr_add_in(padd),
        .ptr_sub_in(psub), .ptr_operand_in(pop), .flash_timing_config_out(tcfg),
        .prog_mem_data_buffer_out(dbuf), .prog_mem_address_pointer_out(ptr),
        .mem_addr_out(maddr), .mem_wdata_out(mwd), .pram_rd_out(prd), .pram_wr_out(pwr),
        .pram_rdata_in(prdata), .flash_rd_out(frd), .flash_write_out(fwr),
        .flash_erase_out(fer), .flash_tick_out(tick), .flash_rdata_in(frdata),
        .flash_done_in(done)
    );
    mem_model mem (
        .sys_clk_in(clk), .addr_in(maddr), .wdata_in(mwd), .pram_rd_in(prd),
        .pram_wr_in(pwr), .flash_rd_in(frd), .flash_prog_in(fwr | fer),
        .pram_rdata_out(prdata), .flash_rdata_out(frdata), .flash_done_out(done)
    );
    // Shared compare, verdict and bus helpers
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic close_out;
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wr(input reg_sel_t s, input logic [7:0] d);
        @(posedge clk);
        rw <= 1'b1;
        rs <= s;
        rd <= d;
        @(posedge clk);
        rw <= 1'b0;
    endtask
    task automatic setp(input logic [23:0] p);
        wr(SEL_ADDR_UP, p[23:16]);
        wr(SEL_ADDR_MID, p[15:8]);
        wr(SEL_ADDR_LO, p[7:0]);
    endtask
    task automatic padj(input logic sub, input logic [7:0] v, input logic [23:0] e);
        @(posedge clk);
        padd <= ~sub;
        psub <= sub;
        pop <= v;
        @(posedge clk);
        padd <= 1'b0;
        psub <= 1'b0;
        #1;
        chk("pointer", e, ptr);
    endtask
    // Issue one instruction; returns one ns into the cycle after it
    task automatic issue(input op_t o, input logic fl, input logic pm, input logic en);
        @(posedge clk);
        iv <= 1'b1;
        op <= o;
        eff <= fl;
        wp <= pm;
        #1;
        chk("nop", {23'h0, en}, {23'h0, nop});
        @(posedge clk);
        iv <= 1'b0;
        #1;
    endtask
    task automatic stalls(output int n);
        n = 0;
        while (stall === 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
            #1;
        end
    endtask
    // Cycles between two pulses of the core enable or the time base
    task automatic gap(input logic which, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((which ? tick : ce) !== 1'b1 && n < 400);
    endtask
    // Scenarios
    task automatic t_regs;
        #1;
        chk("reset", 24'h0, {tcfg, dbuf | {15'h0, busy | stall}});
        chk("reset ptr", 24'h0, ptr);
        setp(24'h00_12FF);
        padj(1'b0, 8'h01, 24'h00_1300);
        padj(1'b1, 8'h01, 24'h00_12FF);
        setp(24'h01_0000);
        padj(1'b1, 8'h01, 24'h00_FFFF);
        wr(SEL_DATA_HI, 8'hBE);
        wr(SEL_DATA_LO, 8'hEF);
        #1;
        chk("buffer", 24'h00_BEEF, {8'h00, dbuf});
    endtask
    task automatic t_ram;
        int n;
        setp(24'h00_0005);
        issue(OP_WRITE_INC, 1'b0, 1'b1, 1'b0);
        chk("ram write", 24'h01_BEEF, {7'h0, pwr, mwd});
        stalls(n);
        chk("stall", 24'h3, 24'(n));
        chk("pointer", 24'h00_0006, ptr);
        setp(24'h00_0005);
        wr(SEL_DATA_LO, 8'h00);
        issue(OP_READ_INC, 1'b1, 1'b1, 1'b0);
        chk("ram read", 24'h01_0005, {7'h0, prd, maddr[15:0]});
        stalls(n);
        chk("stall", 24'h3, 24'(n));
        chk("read back", 24'h00_BEEF, {8'h00, dbuf});
        chk("pointer", 24'h00_0006, ptr);
    endtask
    task automatic t_nops;
        op_t ol [7] = '{OP_WRITE, OP_FL_WRITE, OP_FL_ERASE, OP_FL_WRITE, OP_WRITE_INC,
                        OP_FL_ERASE, OP_READ};
        logic [23:0] pl [7] = '{24'h01_0010, 24'h00_0010, 24'h00_0010, 24'h01_0010,
                                24'h01_0010, 24'h01_0010, 24'hFF_0010};
        logic [6:0] fl = 7'b001_1100;
        logic [6:0] pm = 7'b101_1111;
        for (int i = 0; i < 7; i++) begin
            setp(pl[i]);
            issue(ol[i], fl[i], pm[i], 1'b1);
            chk("strobes", 24'h0, {18'h0, busy, prd, pwr, frd, fwr, fer});
            chk("pointer", pl[i], ptr);
        end
    endtask
    task automatic t_fread;
        int n;
        for (int c = 0; c < 4; c++) begin
            wr(SEL_TIMING, 8'(c << 4));
            setp(24'h01_0040 + 24'(c));
            issue(OP_READ, 1'b0, 1'b1, 1'b0);
            chk("no stall busy", 24'h1, {22'h0, stall, busy});
            n = 0;
            while (frd === 1'b1 && n < 9) begin
                n++;
                @(posedge clk);
                #1;
            end
            chk("read cycles", 24'(c + 1), 24'(n));
            chk("buffer", {8'h00, 8'h40 + 8'(c), ~(8'h40 + 8'(c))}, {8'h00, dbuf});
            @(posedge clk);
            #1;
            chk("busy", 24'h0, {23'h0, busy});
        end
        wr(SEL_TIMING, 8'h00);
        issue(OP_READ, 1'b1, 1'b1, 1'b0);
        stalls(n);
        chk("stall", 24'h3, 24'(n));
    endtask
    task automatic t_ce;
        int n;
        for (int c = 0; c < 4; c++) begin
            wr(SEL_TIMING, 8'(c << 6));
            gap(1'b0, n);
            gap(1'b0, n);
            chk("exec gap", 24'(c + 1), 24'(n));
        end
        spd <= 8'h03;
        wr(SEL_TIMING, 8'h40);
        #1;
        chk("timing", 24'h00_0040, {16'h0000, tcfg});
        gap(1'b0, n);
        gap(1'b0, n);
        chk("slower gap", 24'h3, 24'(n));
        eff <= 1'b0;
        spd <= 8'h02;
        gap(1'b0, n);
        gap(1'b0, n);
        chk("ram gap", 24'h2, 24'(n));
        spd <= 8'h01;
        wr(SEL_TIMING, 8'h00);
    endtask
    task automatic t_prog;
        logic [23:0] pa [3] = '{24'h01_01A5, 24'h01_0022, 24'h02_03FE};
        logic [23:0] ea [3] = '{24'h01_0000, 24'h01_0022, 24'h02_0200};
        logic [7:0] sv [3] = '{8'h0C, 8'h0B, 8'h09};
        logic [7:0] sp [3] = '{8'h02, 8'h03, 8'h05};
        int dv [3] = '{256, 288, 240};
        int n;
        for (int i = 0; i < 3; i++) begin
            wr(SEL_TIMING, sv[i]);
            spd <= sp[i];
            setp(pa[i]);
            issue(i == 1 ? OP_FL_WRITE : OP_FL_ERASE, 1'b0, 1'b1, 1'b0);
            chk("launch", 24'h3, {22'h0, i == 1 ? fwr : fer, busy});
            chk("mem addr", ea[i], maddr);
            gap(1'b1, n);
            gap(1'b1, n);
            chk("tick gap", 24'(dv[i]), 24'(n));
            issue(OP_READ, 1'b0, 1'b1, 1'b1);
            repeat (3) @(posedge clk);
            n = 0;
            while (busy !== 1'b0 && n < 1000) begin
                n++;
                @(posedge clk);
                #1;
            end
            chk("busy clear", 24'h0, {23'h0, busy});
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_regs();
        t_ram();
        t_nops();
        t_fread();
        t_ce();
        t_prog();
        close_out();
    end
endmodule
`default_nettype wire
